// ==== logic/scep_map.svh ====
// Opcode, address, lock range, reset and timing constants of the SPI command port
`ifndef SCEP_MAP_SVH
`define SCEP_MAP_SVH
`define SCEP_OP_WEL_SET 8'h06
`define SCEP_OP_WEL_CLR 8'h04
`define SCEP_OP_NVM_WR 8'h02
`define SCEP_OP_NVM_RD 8'h03
`define SCEP_OP_NVM_STAT 8'h05
`define SCEP_OP_CFG_WR 8'h09
`define SCEP_OP_CTL_WR 8'h0A
`define SCEP_OP_STAT_RD 8'h0B
`define SCEP_OP_LOCK 8'h01
`define SCEP_ADDR_TOP 9'h1FF
`define SCEP_WORDS 512
`define SCEP_PAGE_BYTES 16
`define SCEP_LK1_LO 9'h000
`define SCEP_LK1_HI 9'h07F
`define SCEP_LK2_LO 9'h080
`define SCEP_LK2_HI 9'h0FF
`define SCEP_LK3_LO 9'h100
`define SCEP_LK3_HI 9'h17F
`define SCEP_LK4_LO 9'h180
`define SCEP_LK4_HI 9'h1FF
`define SCEP_LK5_LO 9'h000
`define SCEP_LK5_HI 9'h0FF
`define SCEP_LK6_LO 9'h000
`define SCEP_LK6_HI 9'h00F
`define SCEP_LK7_LO 9'h1F0
`define SCEP_LK7_HI 9'h1FF
`define SCEP_LOCK_RST 3'h0
`define SCEP_REG_RST 16'h0000
`define SCEP_CLK_PERIOD_NS 4
`define SCEP_WRITE_TIME_NS 1000
`endif

// ==== logic/scep_pkg.sv ====
// Types of the SPI command port
package scep_pkg;
	typedef enum logic [3:0]
	{
		SCEP_ST_OPCODE,
		SCEP_ST_WEL,
		SCEP_ST_ADDR_HI,
		SCEP_ST_ADDR_LO,
		SCEP_ST_WDATA,
		SCEP_ST_RDATA,
		SCEP_ST_STAT,
		SCEP_ST_SREG,
		SCEP_ST_CFG,
		SCEP_ST_CTL,
		SCEP_ST_LOCK,
		SCEP_ST_IGNORE
	} scep_state_type;

	typedef struct packed
	{
		logic oe;
		logic busy;
		logic [7:0] data;
	} scep_tx_type;

	typedef struct packed
	{
		logic [15:0] config_word;
		logic [15:0] control_word;
	} scep_regs_type;
endpackage

// ==== logic/scep_port.sv ====
// SPI command port: serial shifter on the link clock, decoder and memory on the system clock
// Operation
// - Mode 0 link: clock idles low, output bits launched on rising edges.
// - Opcode of eight bits first; all fields move most significant bit first.
// - First input bit taken on first rising edge after select falls.
// - Stopped serial clock resumes shifting at the same bit position.
// - Opcodes 06h and 04h set and clear the write enable latch.
// - Opcodes 02h, 03h, 05h: memory write, memory read, memory status read.
// - Opcodes 09h, 0Ah write two-byte registers; 0Bh reads status.
// - Opcode 01h locks partitions, followed by one partition byte.
// - Nonvolatile writes need the latch set first; clear abandons writes.
// - Latch set only when select rises right after its eight bits.
// - Write address is sixteen bits; only low nine bits are used.
// - Up to sixteen bytes per page; column wraps within the page.
// - Write starts only if select rises right after a data byte.
// - Idle status read returns lock code in low bits, zeros above.
// - Busy status read drives output high until the write completes.
// - Bit pointer keeps advancing while busy is shown on the output.
// - Sequential read auto-increments, wrapping 01FFh to 0000h.
// - Select rising stops driving data and aborts the read.
// - Configuration write takes effect at once in the volatile word.
// - Control write updates the control word with no wait.
// - Status read returns three status bits: regulator settled and faults.
// - Writes into a locked area are blocked.
// - Partition code is the low three bits; code zero locks nothing.
// - Latch cleared at power-up and when a write cycle completes.
// - A later partition byte replaces the earlier one.
`timescale 1ns/1ps
`include "scep_map.svh"
module scep_port
#(
	parameter int WRITE_CYCLES = `SCEP_WRITE_TIME_NS / `SCEP_CLK_PERIOD_NS
)
(
	// System clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	// Device status and registers
	input wire logic [2:0] status_bits,
	output scep_pkg::scep_regs_type regs,
	output logic write_latch,
	output logic nvm_busy,
	output logic [2:0] lock_code
);
	import scep_pkg::*;

	function automatic logic scep_locked(input logic [2:0] code, input logic [8:0] a);
		logic [8:0] lo;
		logic [8:0] hi;
		lo = 9'h000;
		hi = 9'h000;
		case (code)
			3'h1: begin lo = `SCEP_LK1_LO; hi = `SCEP_LK1_HI; end
			3'h2: begin lo = `SCEP_LK2_LO; hi = `SCEP_LK2_HI; end
			3'h3: begin lo = `SCEP_LK3_LO; hi = `SCEP_LK3_HI; end
			3'h4: begin lo = `SCEP_LK4_LO; hi = `SCEP_LK4_HI; end
			3'h5: begin lo = `SCEP_LK5_LO; hi = `SCEP_LK5_HI; end
			3'h6: begin lo = `SCEP_LK6_LO; hi = `SCEP_LK6_HI; end
			3'h7: begin lo = `SCEP_LK7_LO; hi = `SCEP_LK7_HI; end
			default: ;
		endcase
		return (code != 3'h0) && (a >= lo) && (a <= hi);
	endfunction

	scep_tx_type tx_r, tx_nxt;

	// Link side, cleared while select is high
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [6:0] rx_sh_r, rx_sh_nxt;
	logic [7:0] rx_hold_r, rx_hold_nxt;
	logic done_tog_r, done_tog_nxt;
	logic start_tog_r, start_tog_nxt;
	logic [7:0] tx_cur_r, tx_cur_nxt;
	logic busy_cur_r, busy_cur_nxt;
	logic so_r, so_nxt;
	logic so_oe_n_r, so_oe_n_nxt;
	logic bsy_s1_r, bsy_s2_r;

	always_comb
	begin
		bit_cnt_nxt = bit_cnt_r + 3'h1;
		rx_sh_nxt = {rx_sh_r[5:0], si};
		rx_hold_nxt = rx_hold_r;
		done_tog_nxt = done_tog_r;
		start_tog_nxt = start_tog_r;
		tx_cur_nxt = tx_cur_r;
		busy_cur_nxt = busy_cur_r;
		so_oe_n_nxt = so_oe_n_r;
		if (bit_cnt_r == 3'h7)
		begin
			rx_hold_nxt = {rx_sh_r, si};
			done_tog_nxt = ~done_tog_r;
		end
		if (bit_cnt_r == 3'h0)
		begin
			start_tog_nxt = ~start_tog_r;
			tx_cur_nxt = tx_r.data;
			busy_cur_nxt = tx_r.busy;
			so_oe_n_nxt = ~tx_r.oe;
		end
		// Busy taken with the byte covers the two bits before the synchroniser catches up
		if (bit_cnt_r[2:1] == 2'b00)
			so_nxt = busy_cur_nxt | tx_cur_nxt[3'h7 - bit_cnt_r];
		else
			so_nxt = bsy_s2_r | tx_cur_nxt[3'h7 - bit_cnt_r];
	end

	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 7'h00;
			rx_hold_r <= 8'h00;
			done_tog_r <= 1'b0;
			start_tog_r <= 1'b0;
			tx_cur_r <= 8'h00;
			busy_cur_r <= 1'b0;
			so_r <= 1'b0;
			so_oe_n_r <= 1'b1;
			bsy_s1_r <= 1'b0;
			bsy_s2_r <= 1'b0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_hold_r <= rx_hold_nxt;
			done_tog_r <= done_tog_nxt;
			start_tog_r <= start_tog_nxt;
			tx_cur_r <= tx_cur_nxt;
			busy_cur_r <= busy_cur_nxt;
			so_r <= so_nxt;
			so_oe_n_r <= so_oe_n_nxt;
			bsy_s1_r <= tx_r.busy;
			bsy_s2_r <= bsy_s1_r;
		end
	end

	assign so = so_r;
	assign so_oe_n = so_oe_n_r;

	// Crossing into the system clock
	logic cs_s1_r, cs_s2_r, cs_d_r;
	logic dt_s1_r, dt_s2_r, st_s1_r, st_s2_r;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_d_r <= 1'b1;
			dt_s1_r <= 1'b0;
			dt_s2_r <= 1'b0;
			st_s1_r <= 1'b0;
			st_s2_r <= 1'b0;
		end
		else
		begin
			cs_s1_r <= cs_n;
			cs_s2_r <= cs_s1_r;
			cs_d_r <= cs_s2_r;
			dt_s1_r <= done_tog_r;
			dt_s2_r <= dt_s1_r;
			st_s1_r <= start_tog_r;
			st_s2_r <= st_s1_r;
		end
	end

	// Decoder, page buffer and write engine
	logic [7:0] mem [`SCEP_WORDS];
	logic [7:0] pbuf [`SCEP_PAGE_BYTES];
	scep_state_type state_r, state_nxt;
	scep_regs_type regs_r, regs_nxt;
	logic dt_ref_r, dt_ref_nxt, st_ref_r, st_ref_nxt;
	logic cmd_wr_r, cmd_wr_nxt;
	logic [8:0] addr_r, addr_nxt;
	logic [3:0] col_r, col_nxt;
	logic [4:0] wpage_r, wpage_nxt;
	logic [15:0] mask_r, mask_nxt;
	logic have_data_r, have_data_nxt;
	logic partial_r, partial_nxt;
	logic half_r, half_nxt;
	logic [7:0] hold_hi_r, hold_hi_nxt;
	logic wel_r, wel_nxt;
	logic [2:0] lock_r, lock_nxt, lock_new_r, lock_new_nxt;
	logic pend_lock_r, pend_lock_nxt;
	logic nvm_busy_r, nvm_busy_nxt;
	logic [4:0] wr_idx_r, wr_idx_nxt;
	logic [15:0] wcnt_r, wcnt_nxt;
	logic frame_on, byte_ev, start_ev, finish, pb_we, mem_we;
	logic [7:0] rx;
	logic [8:0] mem_wa;

	assign frame_on = !cs_s2_r;
	assign byte_ev = frame_on && (dt_s2_r != dt_ref_r);
	assign start_ev = frame_on && (st_s2_r != st_ref_r);
	assign finish = cs_s2_r && !cs_d_r;
	assign rx = rx_hold_r;
	assign mem_wa = {wpage_r, wr_idx_r[3:0]};

	always_comb
	begin
		state_nxt = state_r;
		regs_nxt = regs_r;
		dt_ref_nxt = frame_on ? dt_s2_r : 1'b0;
		st_ref_nxt = frame_on ? st_s2_r : 1'b0;
		cmd_wr_nxt = cmd_wr_r;
		addr_nxt = addr_r;
		col_nxt = col_r;
		wpage_nxt = wpage_r;
		mask_nxt = mask_r;
		have_data_nxt = have_data_r;
		partial_nxt = partial_r;
		half_nxt = half_r;
		hold_hi_nxt = hold_hi_r;
		wel_nxt = wel_r;
		lock_nxt = lock_r;
		lock_new_nxt = lock_new_r;
		pend_lock_nxt = pend_lock_r;
		nvm_busy_nxt = nvm_busy_r;
		wr_idx_nxt = wr_idx_r;
		wcnt_nxt = wcnt_r;
		tx_nxt = tx_r;
		pb_we = 1'b0;
		mem_we = 1'b0;
		if (byte_ev)
		begin
			partial_nxt = 1'b0;
			unique case (state_r)
				SCEP_ST_OPCODE:
				begin
					case (rx)
						`SCEP_OP_WEL_SET: state_nxt = SCEP_ST_WEL;
						`SCEP_OP_WEL_CLR:
						begin
							wel_nxt = 1'b0;
							state_nxt = SCEP_ST_IGNORE;
						end
						`SCEP_OP_NVM_WR:
						begin
							cmd_wr_nxt = 1'b1;
							mask_nxt = 16'h0000;
							state_nxt = nvm_busy_r ? SCEP_ST_IGNORE : SCEP_ST_ADDR_HI;
						end
						`SCEP_OP_NVM_RD:
						begin
							cmd_wr_nxt = 1'b0;
							state_nxt = SCEP_ST_ADDR_HI;
						end
						`SCEP_OP_NVM_STAT: state_nxt = SCEP_ST_STAT;
						`SCEP_OP_STAT_RD: state_nxt = SCEP_ST_SREG;
						`SCEP_OP_CFG_WR: state_nxt = SCEP_ST_CFG;
						`SCEP_OP_CTL_WR: state_nxt = SCEP_ST_CTL;
						`SCEP_OP_LOCK: state_nxt = nvm_busy_r ? SCEP_ST_IGNORE : SCEP_ST_LOCK;
						default: state_nxt = SCEP_ST_IGNORE;
					endcase
				end
				SCEP_ST_WEL: state_nxt = SCEP_ST_IGNORE;
				SCEP_ST_ADDR_HI:
				begin
					addr_nxt[8] = rx[0];
					state_nxt = SCEP_ST_ADDR_LO;
				end
				SCEP_ST_ADDR_LO:
				begin
					addr_nxt = {addr_r[8], rx};
					col_nxt = rx[3:0];
					if (cmd_wr_r)
					begin
						state_nxt = SCEP_ST_WDATA;
					end
					else
					begin
						state_nxt = SCEP_ST_RDATA;
						tx_nxt.data = mem[addr_nxt];
						tx_nxt.oe = 1'b1;
					end
				end
				SCEP_ST_WDATA:
				begin
					pb_we = 1'b1;
					mask_nxt[col_r] = 1'b1;
					col_nxt = col_r + 4'h1;
					have_data_nxt = 1'b1;
				end
				SCEP_ST_RDATA:
				begin
					addr_nxt = addr_r + 9'h001;
					tx_nxt.data = mem[addr_nxt];
				end
				SCEP_ST_CFG, SCEP_ST_CTL:
				begin
					hold_hi_nxt = rx;
					half_nxt = 1'b1;
					if (half_r)
					begin
						state_nxt = SCEP_ST_IGNORE;
						if (state_r == SCEP_ST_CFG)
							regs_nxt.config_word = {hold_hi_r, rx};
						else
							regs_nxt.control_word = {hold_hi_r, rx};
					end
				end
				SCEP_ST_LOCK:
				begin
					lock_new_nxt = rx[2:0];
					have_data_nxt = 1'b1;
				end
				SCEP_ST_STAT, SCEP_ST_SREG, SCEP_ST_IGNORE: ;
			endcase
		end
		if (start_ev)
			partial_nxt = 1'b1;
		if (state_nxt == SCEP_ST_STAT)
		begin
			tx_nxt.data = {5'h00, lock_r};
			tx_nxt.oe = 1'b1;
		end
		if (state_nxt == SCEP_ST_SREG)
		begin
			tx_nxt.data = {5'h00, status_bits};
			tx_nxt.oe = 1'b1;
		end
		if (state_nxt == SCEP_ST_IGNORE)
			tx_nxt.oe = 1'b0;
		if (nvm_busy_r)
		begin
			if (!wr_idx_r[4])
			begin
				mem_we = mask_r[wr_idx_r[3:0]] && !scep_locked(lock_r, mem_wa);
				wr_idx_nxt = wr_idx_r + 5'h01;
			end
			else if (wcnt_r == 16'h0001)
			begin
				nvm_busy_nxt = 1'b0;
				wel_nxt = 1'b0;
				if (pend_lock_r)
					lock_nxt = lock_new_r;
			end
			else
			begin
				wcnt_nxt = wcnt_r - 16'h0001;
			end
		end
		if (finish)
		begin
			state_nxt = SCEP_ST_OPCODE;
			tx_nxt = '0;
			have_data_nxt = 1'b0;
			half_nxt = 1'b0;
			partial_nxt = 1'b0;
			if (state_r == SCEP_ST_WEL && !partial_r)
				wel_nxt = 1'b1;
			if ((state_r == SCEP_ST_WDATA || state_r == SCEP_ST_LOCK) && have_data_r && !partial_r && wel_r
				&& !nvm_busy_r)
			begin
				nvm_busy_nxt = 1'b1;
				wr_idx_nxt = 5'h00;
				wcnt_nxt = 16'(WRITE_CYCLES);
				wpage_nxt = addr_r[8:4];
				pend_lock_nxt = (state_r == SCEP_ST_LOCK);
				if (state_r == SCEP_ST_LOCK)
					mask_nxt = 16'h0000;
			end
		end
		tx_nxt.busy = nvm_busy_nxt && (state_nxt == SCEP_ST_STAT);
	end

	always_ff @(posedge clk)
	begin
		if (pb_we)
			pbuf[col_r] <= rx;
		if (mem_we)
			mem[mem_wa] <= pbuf[wr_idx_r[3:0]];
		if (!rstn)
		begin
			state_r <= SCEP_ST_OPCODE;
			regs_r <= {`SCEP_REG_RST, `SCEP_REG_RST};
			dt_ref_r <= 1'b0;
			st_ref_r <= 1'b0;
			cmd_wr_r <= 1'b0;
			addr_r <= 9'h000;
			col_r <= 4'h0;
			wpage_r <= 5'h00;
			mask_r <= 16'h0000;
			have_data_r <= 1'b0;
			partial_r <= 1'b0;
			half_r <= 1'b0;
			hold_hi_r <= 8'h00;
			wel_r <= 1'b0;
			lock_r <= `SCEP_LOCK_RST;
			lock_new_r <= `SCEP_LOCK_RST;
			pend_lock_r <= 1'b0;
			nvm_busy_r <= 1'b0;
			wr_idx_r <= 5'h00;
			wcnt_r <= 16'h0000;
			tx_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			regs_r <= regs_nxt;
			dt_ref_r <= dt_ref_nxt;
			st_ref_r <= st_ref_nxt;
			cmd_wr_r <= cmd_wr_nxt;
			addr_r <= addr_nxt;
			col_r <= col_nxt;
			wpage_r <= wpage_nxt;
			mask_r <= mask_nxt;
			have_data_r <= have_data_nxt;
			partial_r <= partial_nxt;
			half_r <= half_nxt;
			hold_hi_r <= hold_hi_nxt;
			wel_r <= wel_nxt;
			lock_r <= lock_nxt;
			lock_new_r <= lock_new_nxt;
			pend_lock_r <= pend_lock_nxt;
			nvm_busy_r <= nvm_busy_nxt;
			wr_idx_r <= wr_idx_nxt;
			wcnt_r <= wcnt_nxt;
			tx_r <= tx_nxt;
		end
	end

	assign regs = regs_r;
	assign write_latch = wel_r;
	assign nvm_busy = nvm_busy_r;
	assign lock_code = lock_r;

	default clocking chk_cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	chk_latch_set_exact: assert property (finish && state_r == SCEP_ST_WEL && !partial_r |=> wel_r)
		else $error("latch not set after clean set command");
	chk_latch_clear_op: assert property (byte_ev && state_r == SCEP_ST_OPCODE && rx == `SCEP_OP_WEL_CLR
		&& !finish |=> !wel_r)
		else $error("latch not cleared by clear command");
	chk_write_needs_latch: assert property ($rose(nvm_busy_r) |-> $past(wel_r) && $past(finish))
		else $error("write cycle started without latch");
	chk_latch_auto_clear: assert property ($fell(nvm_busy_r) && !$past(finish) |-> !wel_r)
		else $error("latch still set after write cycle");
	chk_read_addr_wrap: assert property (byte_ev && state_r == SCEP_ST_RDATA && addr_r == `SCEP_ADDR_TOP
		|=> addr_r == 9'h000 && tx_r.oe)
		else $error("read address did not wrap");
	chk_page_col_wrap: assert property (byte_ev && state_r == SCEP_ST_WDATA |=> col_r == 4'($past(col_r) + 4'h1))
		else $error("page column did not advance");
	chk_locked_no_write: assert property (nvm_busy_r && !wr_idx_r[4] && scep_locked(lock_r, mem_wa)
		|=> mem[$past(mem_wa)] === $past(mem[mem_wa]))
		else $error("write into locked area");
	chk_cfg_word_load: assert property (byte_ev && state_r == SCEP_ST_CFG && half_r
		|=> regs_r.config_word == {$past(hold_hi_r), $past(rx)})
		else $error("configuration word not updated");
	chk_unknown_quiet: assert property (byte_ev && state_r == SCEP_ST_OPCODE && rx == 8'hFF
		|=> state_r == SCEP_ST_IGNORE && !tx_r.oe)
		else $error("unknown opcode not ignored");
	chk_status_byte: assert property (state_r == SCEP_ST_STAT && !finish
		|=> tx_r.data == {5'h00, $past(lock_r)} && tx_r.busy == nvm_busy_r)
		else $error("status byte wrong");

	cov_page_write: cover property ($rose(nvm_busy_r) && !pend_lock_r);
	cov_lock_write: cover property ($fell(nvm_busy_r) && pend_lock_r);
	cov_read_wrap: cover property (byte_ev && state_r == SCEP_ST_RDATA && addr_r == `SCEP_ADDR_TOP);
	cov_busy_status: cover property (tx_r.busy ##1 !tx_r.busy && state_r == SCEP_ST_STAT);
endmodule // scep_port

// ==== bench/scep_host.sv ====
// Host-side SPI master model for the command port, mode 0
`timescale 1ns/1ps
module scep_host
(
	// Serial link
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe_n
);
	logic oe_seen;
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b0;
		oe_seen = 1'b0;
		// One rising select edge clears the link-side flops before any frame
		#1;
		cs_n = 1'b1;
	end
	task automatic sel();
		oe_seen = 1'b0;
		cs_n = 1'b0;
		#24;
	endtask
	task automatic desel();
		#16;
		cs_n = 1'b1;
		si = ~si;
		#41.3;
	endtask
	task automatic xfer(input logic [7:0] tx, input int nbits, input bit stall, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--)
		begin
			si = tx[i];
			#24;
			sck = 1'b1;
			#24;
			rx[i] = so;
			if (so_oe_n === 1'b0)
				oe_seen = 1'b1;
			sck = 1'b0;
			if (stall && i == 4)
				#500;
		end
	endtask
endmodule // scep_host

// ==== bench/test_scep_port.sv ====
// Self-checking bench of the SPI command port against a reference model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_scep_port;
	import scep_pkg::*;
	logic clk, rstn, sck, cs_n, si, so, so_oe_n, write_latch, nvm_busy;
	logic [2:0] status_bits;
	logic [2:0] lock_code;
	scep_regs_type regs;
	int err_count = 0;
	int n_compared = 0;
	int lk = 0;
	bit wel = 0;
	logic [7:0] mem [512];
	logic [7:0] rxq [$];
	logic [15:0] cfg = 16'h0000;
	logic [15:0] ctl = 16'h0000;
	scep_port #(.WRITE_CYCLES(200)) uut (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe_n(so_oe_n), .status_bits(status_bits), .regs(regs), .write_latch(write_latch),
		.nvm_busy(nvm_busy), .lock_code(lock_code));
	scep_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#300000;
		err_count++;
		$display("unexpected at %0t: run did not finish", $time);
		close_out();
	end
	task automatic frame(input logic [7:0] q [$], input int nrd, input int tail, input bit stall);
		logic [7:0] rx;
		rxq = {};
		host.sel();
		foreach (q[i])
			host.xfer(q[i], 8, 1'b0, rx);
		for (int i = 0; i < nrd; i++)
		begin
			host.xfer(8'($urandom), 8, stall, rx);
			rxq.push_back(rx);
		end
		if (tail > 0)
			host.xfer(8'hA5, tail, 1'b0, rx);
		host.desel();
	endtask
	function automatic bit locked(int a);
		case (lk)
			1: return a < 'h80;
			2: return a >= 'h80 && a < 'h100;
			3: return a >= 'h100 && a < 'h180;
			4: return a >= 'h180;
			5: return a < 'h100;
			6: return a < 'h10;
			7: return a >= 'h1F0;
			default: return 1'b0;
		endcase
	endfunction
	task automatic wait_idle();
		int n = 0;
		while (nvm_busy !== 1'b0 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		`CHK(n < 2000, 1'b1)
	endtask
	task automatic wr_en();
		frame({8'h06}, 0, 0, 1'b0);
		wel = 1'b1;
		`CHK(write_latch, 1'b1)
	endtask
	task automatic nvm_wr(input int a, input int n);
		logic [7:0] q [$];
		logic [7:0] d;
		int ad;
		q = {8'h02, 8'(a >> 8), 8'(a)};
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			q.push_back(d);
			ad = (a & 'h1F0) | ((a + i) & 'hF);
			if (wel && !locked(ad))
				mem[ad] = d;
		end
		frame(q, 0, 0, 1'b0);
		wel = 1'b0;
	endtask
	task automatic nvm_rd(input int a, input int n, input bit stall);
		frame({8'h03, 8'(a >> 8), 8'(a)}, n, 0, stall);
		for (int i = 0; i < n; i++)
			`CHK(rxq[i], mem[(a + i) % 512])
	endtask
	initial
	begin
		rstn = 1'b0;
		status_bits = 3'h0;
		void'($urandom(71));
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		`CHK({regs, write_latch, nvm_busy, lock_code}, 37'h0)
		wr_en();
		frame({8'h04}, 0, 0, 1'b0);
		`CHK(write_latch, 1'b0)
		frame({8'h06, 8'h00}, 0, 0, 1'b0);
		`CHK(write_latch, 1'b0)
		$display("test latch done");
		wr_en();
		nvm_wr(0, 16);
		wait_idle();
		wr_en();
		nvm_wr('h1F8, 18);
		frame({8'h05}, 3, 0, 1'b0);
		`CHK(rxq[0], 8'hFF)
		`CHK(rxq[2], 8'h00)
		wait_idle();
		`CHK(write_latch, 1'b0)
		nvm_rd('h1FE, 4, 1'b1);
		`CHK(so_oe_n, 1'b1)
		nvm_wr(2, 1);
		nvm_rd(2, 1, 1'b0);
		wr_en();
		frame({8'h02, 8'h00, 8'h03, 8'h77}, 0, 4, 1'b0);
		wait_idle();
		nvm_rd(3, 1, 1'b0);
		frame({8'h04}, 0, 0, 1'b0);
		$display("test memory done");
		for (int c = 0; c < 8; c++)
		begin
			wr_en();
			frame({8'h01, 8'(7 - c), 8'(c)}, 0, 0, 1'b0);
			wait_idle();
			lk = c;
			wel = 1'b0;
			`CHK(lock_code, 3'(c))
			frame({8'h05}, 1, 0, 1'b0);
			`CHK(rxq[0], 8'(c))
			wr_en();
			nvm_wr(0, 16);
			wait_idle();
			nvm_rd(0, 16, 1'b0);
		end
		$display("test lock done");
		for (int k = 0; k < 4; k++)
		begin
			logic [15:0] v;
			v = 16'($urandom);
			frame({k % 2 ? 8'h0A : 8'h09, v[15:8], v[7:0], 8'($urandom)}, 0, 0, 1'b0);
			if (k % 2)
				ctl = v;
			else
				cfg = v;
			`CHK(regs.config_word, cfg)
			`CHK(regs.control_word, ctl)
		end
		for (int k = 0; k < 4; k++)
		begin
			logic [2:0] s;
			s = 3'($urandom);
			@(negedge clk);
			status_bits = s;
			frame({8'h0B}, 2, 0, 1'b0);
			`CHK(rxq[0], {5'h00, s})
			`CHK(rxq[1], {5'h00, s})
		end
		frame({8'hFF}, 2, 0, 1'b0);
		`CHK(host.oe_seen, 1'b0)
		$display("test registers done");
		close_out();
	end
endmodule // test_scep_port
